// ===== rtl/eac_accept_copy.sv
`timescale 1ns/1ps
// Function
// [R1] leaf 07H only, inside enclave only
// [R2] misaligned 64-byte security info: gp fault
// [R3] misaligned 4K source or destination: gp fault
// [R4] operand outside enclave linear range: gp fault
// [R5] not in page cache: page fault, in order
// [R6] security-info page metadata checked, else page fault
// [R7] latch 512-bit security info, use copy after
// [R8] bad latched flags or type: gp fault
// [R9] source page metadata checked, else page fault
// [R10] destination unacceptable: zero flag, mismatch code
// [R11] destination in use: gp fault
// [R12] claimed destination re-checked, else page fault
// [R13] copy all 4096 source bytes to destination
// [R14] OR latched permissions in, clear awaiting-accept
// [R15] success clears zero flag and result code
// [R16] normal completion clears carry, parity, adjust, overflow, sign
// [R17] segment limit or non-canonical operand: gp fault
// [R18] locked operand access: gp fault
// [R19] first failure only, nothing changed on failure
module eac_accept_copy
	import eac_pkg::*;
#(
	parameter logic [31:0] ATTR_MISMATCH_CODE = 32'h0000_0001
) (
	input  wire logic          clk,
	input  wire logic          reset,
	input  wire logic          ce,
	input  wire eac_bus_type   bus,
	output logic [31:0]        bus_rdata,
	input  wire logic          op_valid,
	input  wire eac_op_type    op,
	output logic               busy,
	output logic               done,
	output logic               gp_fault,
	output logic               pf_fault,
	output logic [31:0]        fault_addr,
	output logic [31:0]        result_code,
	output eac_flags_type      flags,
	input  wire logic          dest_in_use,
	output logic               dest_claim,
	output logic               meta_rd,
	output logic               meta_wr,
	output logic [19:0]        meta_page,
	output eac_meta_type       meta_wdata,
	input  wire eac_meta_type  meta_rdata,
	output logic               mem_rd,
	output logic               mem_wr,
	output logic [28:0]        mem_addr,
	output logic [63:0]        mem_wdata,
	input  wire logic [63:0]   mem_rdata,
	output logic               irq
);

	function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo,
		input logic [31:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction : in_rng

	function automatic logic seg_over(input logic [31:0] a, input logic [31:0] ofs,
		input logic [31:0] lim);
		logic [32:0] last;
		last = {1'b0, a} + {1'b0, ofs};
		seg_over = last > {1'b0, lim};
	endfunction : seg_over

	function automatic logic page_good(input eac_meta_type m, input logic [31:0] a,
		input logic [31:0] own);
		page_good = m.valid && !m.pending && !m.modified && !m.blocked &&
			(m.ptype == EAC_REGULAR_PAGE_TYPE) && (m.owner == own) && (m.laddr == a);
	endfunction : page_good

	function automatic logic [19:0] page_of(input logic [31:0] a);
		page_of = a[31:EAC_PAGE_BITS];
	endfunction : page_of

	// registers
	eac_state_type  state_r, state_nxt;
	eac_op_type     op_r;
	logic [511:0]   si_r;
	eac_meta_type   dst_r;
	logic [8:0]     idx_r, idx_nxt;
	logic [3:0]     sts_r, mask_r;
	logic [31:0]    elr_lo_r, elr_hi_r, ppc_lo_r, ppc_hi_r, active_r;
	logic           mem_rv_r, meta_rv_r;
	logic           claim_nxt, mem_rd_nxt, mem_wr_nxt, meta_rd_nxt, meta_wr_nxt;
	logic [28:0]    mem_addr_nxt;
	logic [63:0]    mem_wdata_nxt;
	logic [19:0]    meta_page_nxt;
	eac_meta_type   meta_wdata_nxt;

	// events of this cycle
	logic           take, ev_gp, ev_pf, ev_mis, ev_ok;
	logic [31:0]    ev_addr;
	logic           pre_gp, pre_pf;
	logic [31:0]    pre_addr;
	logic [63:0]    si_w0;
	logic [7:0]     si_pt;
	logic           si_bad;

	assign si_w0 = si_r[63:0];
	assign si_pt = si_w0[EAC_SI_PT_LSB +: 8];

	// all checks on the latched copy, never on live memory
	assign si_bad = ((si_w0 & EAC_SI_W0_RSVD_MASK) != 64'h0000_0000_0000_0000) ||
		(si_r[511:64] != '0) ||
		(!si_w0[EAC_SI_R_BIT] && si_w0[EAC_SI_W_BIT]) ||
		(si_pt != EAC_REGULAR_PAGE_TYPE); // see [R7] see [R8]

	// operand checks that need no memory, in priority order
	always_comb begin
		pre_gp = 1'b1;
		pre_pf = 1'b0;
		pre_addr = '0;
		if (!op.in_enclave) begin
			pre_gp = 1'b1; // see [R1]
		end else if (op.locked) begin
			pre_gp = 1'b1; // see [R18]
		end else if (op.mode64 ? (op.noncanon != 3'h0) :
			(seg_over(op.si_ptr, EAC_SI_LAST_OFS, op.seg_limit) ||
			seg_over(op.dst_ptr, EAC_PAGE_LAST_OFS, op.seg_limit) ||
			seg_over(op.src_ptr, EAC_PAGE_LAST_OFS, op.seg_limit))) begin
			pre_gp = 1'b1; // see [R17]
		end else if (op.si_ptr[EAC_SI_ALIGN_BITS-1:0] != '0) begin
			pre_gp = 1'b1; // see [R2]
		end else if ((op.dst_ptr[EAC_PAGE_BITS-1:0] != '0) ||
			(op.src_ptr[EAC_PAGE_BITS-1:0] != '0)) begin
			pre_gp = 1'b1; // see [R3]
		end else if (!in_rng(op.si_ptr, elr_lo_r, elr_hi_r) ||
			!in_rng(op.dst_ptr, elr_lo_r, elr_hi_r) ||
			!in_rng(op.src_ptr, elr_lo_r, elr_hi_r)) begin
			pre_gp = 1'b1; // see [R4]
		end else if (!in_rng(op.si_ptr, ppc_lo_r, ppc_hi_r)) begin
			pre_gp = 1'b0; // see [R5]
			pre_pf = 1'b1;
			pre_addr = op.si_ptr;
		end else if (!in_rng(op.dst_ptr, ppc_lo_r, ppc_hi_r)) begin
			pre_gp = 1'b0; // see [R5]
			pre_pf = 1'b1;
			pre_addr = op.dst_ptr;
		end else if (!in_rng(op.src_ptr, ppc_lo_r, ppc_hi_r)) begin
			pre_gp = 1'b0; // see [R5]
			pre_pf = 1'b1;
			pre_addr = op.src_ptr;
		end else begin
			pre_gp = 1'b0;
		end
	end

	// sequencer: every failing step leaves memory and metadata untouched
	always_comb begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		take = 1'b0;
		ev_gp = 1'b0;
		ev_pf = 1'b0;
		ev_mis = 1'b0;
		ev_ok = 1'b0;
		ev_addr = '0;
		claim_nxt = dest_claim;
		mem_rd_nxt = 1'b0;
		mem_wr_nxt = 1'b0;
		mem_addr_nxt = mem_addr;
		mem_wdata_nxt = mem_wdata;
		meta_rd_nxt = 1'b0;
		meta_wr_nxt = 1'b0;
		meta_page_nxt = meta_page;
		meta_wdata_nxt = meta_wdata;
		unique case (state_r)
			S_IDLE: begin
				if (op_valid && (op.leaf == EAC_LEAF_ACCEPT_COPY)) begin // see [R1]
					take = 1'b1;
					if (pre_gp) begin
						ev_gp = 1'b1; // see [R19]
					end else if (pre_pf) begin
						ev_pf = 1'b1;
						ev_addr = pre_addr;
					end else begin
						meta_rd_nxt = 1'b1;
						meta_page_nxt = page_of(op.si_ptr);
						state_nxt = S_VSI;
					end
				end
			end
			S_VSI: begin
				if (meta_rv_r) begin
					if (!(page_good(meta_rdata, op_r.si_ptr, active_r) && meta_rdata.r)) begin
						ev_pf = 1'b1; // see [R6]
						ev_addr = op_r.si_ptr;
					end else begin
						idx_nxt = '0;
						state_nxt = S_RSI;
					end
				end
			end
			S_RSI: begin
				mem_rd_nxt = 1'b1;
				mem_addr_nxt = op_r.si_ptr[31:3] + {20'h0_0000, idx_r};
				state_nxt = S_CSI;
			end
			S_CSI: begin
				if (mem_rv_r) begin
					if (idx_r == EAC_SI_LAST_WORD) begin
						state_nxt = S_FSI;
					end else begin
						idx_nxt = idx_r + 9'h001;
						state_nxt = S_RSI;
					end
				end
			end
			S_FSI: begin
				if (si_bad) begin
					ev_gp = 1'b1; // see [R8]
				end else begin
					meta_rd_nxt = 1'b1;
					meta_page_nxt = page_of(op_r.src_ptr);
					state_nxt = S_VSRC;
				end
			end
			S_VSRC: begin
				if (meta_rv_r) begin
					if (!page_good(meta_rdata, op_r.src_ptr, active_r)) begin
						ev_pf = 1'b1; // see [R9]
						ev_addr = op_r.src_ptr;
					end else begin
						meta_rd_nxt = 1'b1;
						meta_page_nxt = page_of(op_r.dst_ptr);
						state_nxt = S_VDST;
					end
				end
			end
			S_VDST: begin
				if (meta_rv_r) begin
					if (!meta_rdata.valid || !meta_rdata.pending || meta_rdata.modified ||
						(meta_rdata.ptype != EAC_REGULAR_PAGE_TYPE) ||
						(meta_rdata.owner != active_r)) begin
						ev_mis = 1'b1; // see [R10]
					end else begin
						state_nxt = S_CLAIM;
					end
				end
			end
			S_CLAIM: begin
				if (dest_in_use) begin
					ev_gp = 1'b1; // see [R11]
				end else begin
					claim_nxt = 1'b1;
					meta_rd_nxt = 1'b1;
					meta_page_nxt = page_of(op_r.dst_ptr);
					state_nxt = S_VDST2;
				end
			end
			S_VDST2: begin
				if (meta_rv_r) begin
					if (!meta_rdata.valid || !meta_rdata.pending || meta_rdata.modified ||
						!meta_rdata.r || !meta_rdata.w || meta_rdata.x ||
						(meta_rdata.ptype != si_pt) || (meta_rdata.owner != active_r) ||
						(meta_rdata.laddr != op_r.dst_ptr)) begin
						ev_pf = 1'b1; // see [R12]
						ev_addr = op_r.dst_ptr;
					end else begin
						idx_nxt = '0;
						state_nxt = S_CRD;
					end
				end
			end
			S_CRD: begin
				mem_rd_nxt = 1'b1;
				mem_addr_nxt = op_r.src_ptr[31:3] + {20'h0_0000, idx_r}; // see [R13]
				state_nxt = S_CWR;
			end
			S_CWR: begin
				if (mem_rv_r) begin
					mem_wr_nxt = 1'b1;
					mem_addr_nxt = op_r.dst_ptr[31:3] + {20'h0_0000, idx_r}; // see [R13]
					mem_wdata_nxt = mem_rdata;
					if (idx_r == EAC_PAGE_LAST_WORD) begin
						state_nxt = S_UPD;
					end else begin
						idx_nxt = idx_r + 9'h001;
						state_nxt = S_CRD;
					end
				end
			end
			S_UPD: begin
				meta_wr_nxt = 1'b1;
				meta_page_nxt = page_of(op_r.dst_ptr);
				meta_wdata_nxt = dst_r;
				meta_wdata_nxt.r = dst_r.r | si_w0[EAC_SI_R_BIT]; // see [R14]
				meta_wdata_nxt.w = dst_r.w | si_w0[EAC_SI_W_BIT];
				meta_wdata_nxt.x = dst_r.x | si_w0[EAC_SI_X_BIT];
				meta_wdata_nxt.pending = 1'b0;
				ev_ok = 1'b1;
			end
			default: begin
				state_nxt = S_IDLE;
			end
		endcase
		if (ev_gp || ev_pf || ev_mis || ev_ok) begin
			state_nxt = S_IDLE;
			claim_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= S_IDLE;
			idx_r <= '0;
			busy <= 1'b0;
			dest_claim <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
			busy <= (state_nxt != S_IDLE);
			dest_claim <= claim_nxt;
		end
	end

	// operand and latched copies
	always_ff @(posedge clk) begin
		if (reset) begin
			op_r <= '0;
			si_r <= '0;
			dst_r <= '0;
		end else if (ce) begin
			if (take) begin
				op_r <= op;
			end
			if ((state_r == S_CSI) && mem_rv_r) begin
				si_r[idx_r[2:0]*64 +: 64] <= mem_rdata; // see [R7]
			end
			if ((state_r == S_VDST2) && meta_rv_r) begin
				dst_r <= meta_rdata;
			end
		end
	end

	// memory and metadata strobes; responses come one cycle after a read
	always_ff @(posedge clk) begin
		if (reset) begin
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_addr <= '0;
			mem_wdata <= '0;
			meta_rd <= 1'b0;
			meta_wr <= 1'b0;
			meta_page <= '0;
			meta_wdata <= '0;
			mem_rv_r <= 1'b0;
			meta_rv_r <= 1'b0;
		end else if (ce) begin
			mem_rd <= mem_rd_nxt;
			mem_wr <= mem_wr_nxt;
			mem_addr <= mem_addr_nxt;
			mem_wdata <= mem_wdata_nxt;
			meta_rd <= meta_rd_nxt;
			meta_wr <= meta_wr_nxt;
			meta_page <= meta_page_nxt;
			meta_wdata <= meta_wdata_nxt;
			mem_rv_r <= mem_rd;
			meta_rv_r <= meta_rd;
		end
	end

	// architectural outcome; faults leave flags and result untouched
	always_ff @(posedge clk) begin
		if (reset) begin
			done <= 1'b0;
			gp_fault <= 1'b0;
			pf_fault <= 1'b0;
			fault_addr <= '0;
			result_code <= EAC_REG_RESET;
			flags <= '0;
		end else if (ce) begin
			done <= ev_ok || ev_mis;
			gp_fault <= ev_gp;
			pf_fault <= ev_pf;
			if (ev_gp || ev_pf) begin
				fault_addr <= ev_addr;
			end
			if (ev_ok) begin
				result_code <= EAC_RESULT_OK; // see [R15]
				flags <= '0; // see [R16]
			end else if (ev_mis) begin
				result_code <= ATTR_MISMATCH_CODE; // see [R10]
				flags <= '0; // see [R16]
				flags.zf <= 1'b1;
			end
		end
	end

	// software registers
	logic [3:0] sts_set;
	assign sts_set = {ev_mis, ev_pf, ev_gp, ev_ok || ev_mis};

	always_ff @(posedge clk) begin
		if (reset) begin
			sts_r <= EAC_ST_RESET;
			mask_r <= EAC_ST_RESET;
			elr_lo_r <= EAC_REG_RESET;
			elr_hi_r <= EAC_REG_RESET;
			ppc_lo_r <= EAC_REG_RESET;
			ppc_hi_r <= EAC_REG_RESET;
			active_r <= EAC_REG_RESET;
		end else if (ce) begin
			// a new event beats a clear in the same cycle
			if (bus.wr && (bus.addr == EAC_OFS_STATUS)) begin
				sts_r <= (sts_r & ~bus.wdata[3:0]) | sts_set;
			end else begin
				sts_r <= sts_r | sts_set;
			end
			if (bus.wr) begin
				unique case (bus.addr)
					EAC_OFS_MASK:   mask_r <= bus.wdata[3:0];
					EAC_OFS_ELR_LO: elr_lo_r <= bus.wdata;
					EAC_OFS_ELR_HI: elr_hi_r <= bus.wdata;
					EAC_OFS_PPC_LO: ppc_lo_r <= bus.wdata;
					EAC_OFS_PPC_HI: ppc_hi_r <= bus.wdata;
					EAC_OFS_ACTIVE: active_r <= bus.wdata;
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			bus_rdata <= '0;
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(sts_r & mask_r);
			bus_rdata <= '0;
			if (bus.rd) begin
				unique case (bus.addr)
					EAC_OFS_STATUS: bus_rdata <= {28'h000_0000, sts_r};
					EAC_OFS_MASK:   bus_rdata <= {28'h000_0000, mask_r};
					EAC_OFS_ELR_LO: bus_rdata <= elr_lo_r;
					EAC_OFS_ELR_HI: bus_rdata <= elr_hi_r;
					EAC_OFS_PPC_LO: bus_rdata <= ppc_lo_r;
					EAC_OFS_PPC_HI: bus_rdata <= ppc_hi_r;
					EAC_OFS_ACTIVE: bus_rdata <= active_r;
					EAC_OFS_RESULT: bus_rdata <= result_code;
					EAC_OFS_FADDR:  bus_rdata <= fault_addr;
					EAC_OFS_STATE:  bus_rdata <= {27'h000_0000, dest_claim, state_r};
					default:        bus_rdata <= '0;
				endcase
			end
		end
	end

endmodule : eac_accept_copy

// ===== rtl/eac_pkg.sv
package eac_pkg;

	// operation selector and result values
	localparam logic [31:0] EAC_LEAF_ACCEPT_COPY = 32'h0000_0007;
	localparam logic [31:0] EAC_RESULT_OK        = 32'h0000_0000;

	// geometry
	localparam int unsigned EAC_SI_ALIGN_BITS   = 6;
	localparam int unsigned EAC_PAGE_BITS       = 12;
	localparam logic [31:0] EAC_SI_LAST_OFS     = 32'h0000_003F;
	localparam logic [31:0] EAC_PAGE_LAST_OFS   = 32'h0000_0FFF;
	localparam logic [8:0]  EAC_SI_LAST_WORD    = 9'h007;
	localparam logic [8:0]  EAC_PAGE_LAST_WORD  = 9'h1FF;

	// security-info word 0 layout; words 1..7 are reserved
	localparam int unsigned EAC_SI_R_BIT        = 0;
	localparam int unsigned EAC_SI_W_BIT        = 1;
	localparam int unsigned EAC_SI_X_BIT        = 2;
	localparam int unsigned EAC_SI_PT_LSB       = 8;
	localparam logic [63:0] EAC_SI_W0_RSVD_MASK = 64'hFFFF_FFFF_FFFF_00F8;
	localparam logic [7:0]  EAC_REGULAR_PAGE_TYPE = 8'h01;

	// register offsets
	localparam logic [7:0] EAC_OFS_STATUS  = 8'h00;
	localparam logic [7:0] EAC_OFS_MASK    = 8'h04;
	localparam logic [7:0] EAC_OFS_ELR_LO  = 8'h08;
	localparam logic [7:0] EAC_OFS_ELR_HI  = 8'h0C;
	localparam logic [7:0] EAC_OFS_PPC_LO  = 8'h10;
	localparam logic [7:0] EAC_OFS_PPC_HI  = 8'h14;
	localparam logic [7:0] EAC_OFS_ACTIVE  = 8'h18;
	localparam logic [7:0] EAC_OFS_RESULT  = 8'h1C;
	localparam logic [7:0] EAC_OFS_FADDR   = 8'h20;
	localparam logic [7:0] EAC_OFS_STATE   = 8'h24;

	// status / mask bits
	localparam int unsigned EAC_ST_DONE = 0;
	localparam int unsigned EAC_ST_GP   = 1;
	localparam int unsigned EAC_ST_PF   = 2;
	localparam int unsigned EAC_ST_MIS  = 3;
	localparam logic [3:0]  EAC_ST_RESET = 4'h0;
	localparam logic [31:0] EAC_REG_RESET = 32'h0000_0000;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} eac_bus_type;

	typedef struct packed {
		logic [31:0] leaf;
		logic [31:0] si_ptr;
		logic [31:0] dst_ptr;
		logic [31:0] src_ptr;
		logic        in_enclave;
		logic        mode64;
		logic [31:0] seg_limit;
		logic [2:0]  noncanon;
		logic        locked;
	} eac_op_type;

	typedef struct packed {
		logic        valid;
		logic        r;
		logic        w;
		logic        x;
		logic        pending;
		logic        modified;
		logic        blocked;
		logic [7:0]  ptype;
		logic [31:0] owner;
		logic [31:0] laddr;
	} eac_meta_type;

	typedef struct packed {
		logic zf;
		logic cf;
		logic pf;
		logic af;
		logic of;
		logic sf;
	} eac_flags_type;

	typedef enum logic [3:0] {
		S_IDLE  = 4'h0,
		S_VSI   = 4'h1,
		S_RSI   = 4'h2,
		S_CSI   = 4'h3,
		S_FSI   = 4'h4,
		S_VSRC  = 4'h5,
		S_VDST  = 4'h6,
		S_CLAIM = 4'h7,
		S_VDST2 = 4'h8,
		S_CRD   = 4'h9,
		S_CWR   = 4'hA,
		S_UPD   = 4'hB
	} eac_state_type;

endpackage : eac_pkg

// ===== testbench/eac_props.sv
`timescale 1ns/1ps
module eac_props
	import eac_pkg::*;
#(
	parameter logic [31:0] ATTR_MISMATCH_CODE = 32'h0000_0001
) (
	input wire logic          clk,
	input wire logic          reset,
	input wire logic          op_valid,
	input wire eac_op_type    op,
	input wire logic          busy,
	input wire logic          done,
	input wire logic          gp_fault,
	input wire logic          pf_fault,
	input wire logic [31:0]   result_code,
	input wire eac_flags_type flags,
	input wire logic          dest_claim,
	input wire logic          meta_wr,
	input wire eac_meta_type  meta_wdata,
	input wire logic          mem_wr
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic take;
	assign take = op_valid && !busy && op.leaf == EAC_LEAF_ACCEPT_COPY;
	property p_outside;
		take && !op.in_enclave |=> gp_fault && !pf_fault;
	endproperty
	a_outside: assert property (p_outside) else $error("outside enclave not refused");
	property p_locked;
		take && op.locked |=> gp_fault && !pf_fault;
	endproperty
	a_locked: assert property (p_locked) else $error("locked operand not refused");
	property p_si_align;
		take && op.si_ptr[5:0] != 6'h00 |=> gp_fault && !pf_fault;
	endproperty
	a_si_align: assert property (p_si_align) else $error("misaligned info accepted");
	property p_page_align;
		take && (op.dst_ptr[11:0] != 12'h000 || op.src_ptr[11:0] != 12'h000) |=> gp_fault;
	endproperty
	a_page_align: assert property (p_page_align) else $error("misaligned page accepted");
	property p_seg;
		take && !op.mode64 && op.si_ptr > op.seg_limit |=> gp_fault;
	endproperty
	a_seg: assert property (p_seg) else $error("segment limit not enforced");
	property p_mismatch;
		done && !meta_wr |-> flags.zf && result_code == ATTR_MISMATCH_CODE;
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("mismatch result wrong");
	property p_success;
		done && meta_wr |-> !flags.zf && result_code == EAC_RESULT_OK;
	endproperty
	a_success: assert property (p_success) else $error("success result wrong");
	property p_flags;
		done |-> {flags.cf, flags.pf, flags.af, flags.of, flags.sf} == 5'h00;
	endproperty
	a_flags: assert property (p_flags) else $error("arith flags not cleared");
	property p_fault_keeps;
		gp_fault || pf_fault |-> $stable(result_code) && $stable(flags) && !meta_wr && !mem_wr;
	endproperty
	a_fault_keeps: assert property (p_fault_keeps) else $error("fault changed state");
	property p_copy_claimed;
		mem_wr |-> dest_claim;
	endproperty
	a_copy_claimed: assert property (p_copy_claimed) else $error("write without claim");
	property p_upd;
		meta_wr |-> !meta_wdata.pending && meta_wdata.r && meta_wdata.w && done;
	endproperty
	a_upd: assert property (p_upd) else $error("destination update wrong");
	c_success: cover property (done && meta_wr);
	c_mismatch: cover property (done && !meta_wr);
	c_pf: cover property (pf_fault);
endmodule : eac_props

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb
	import eac_pkg::*;
;
	typedef struct packed {
		eac_op_type  op;
		logic [2:0]  t;
		logic [2:0]  gpd;
		logic [31:0] fa;
		logic [9:0]  nw;
	} eac_row_type;
	localparam logic [31:0] SI = 32'h1000_0040, DST = 32'h1000_2000, SRC = 32'h1000_3000;
	localparam logic [31:0] AID = 32'h0000_00AA, MIS = 32'h0000_0014;
	localparam logic [31:0] FAR = 32'h1100_0000;
	logic          clk = 0, reset = 1, op_valid = 0, dest_in_use = 0, ce = 1;
	eac_bus_type   bus = '0;
	eac_op_type    op = '0, o;
	logic [31:0]   bus_rdata, fault_addr, result_code;
	logic          busy, done, gp_fault, pf_fault, dest_claim, meta_rd, meta_wr;
	logic          mem_rd, mem_wr, irq;
	logic [19:0]   meta_page;
	logic [28:0]   mem_addr;
	logic [63:0]   mem_wdata, w0, mem_rdata = '0;
	eac_flags_type flags;
	eac_meta_type  meta_wdata, meta_rdata = '0, m_si, m_src, m_dst, em;
	eac_row_type   rows [17], r;
	int            n_mismatch = 0, comparisons = 0, n_wr = 0, n_mw = 0, n;

	eac_accept_copy #(.ATTR_MISMATCH_CODE(MIS)) i_dut (.clk(clk), .reset(reset), .ce(ce),
		.bus(bus), .bus_rdata(bus_rdata), .op_valid(op_valid), .op(op), .busy(busy),
		.done(done), .gp_fault(gp_fault), .pf_fault(pf_fault), .fault_addr(fault_addr),
		.result_code(result_code), .flags(flags), .dest_in_use(dest_in_use),
		.dest_claim(dest_claim), .meta_rd(meta_rd), .meta_wr(meta_wr), .meta_page(meta_page),
		.meta_wdata(meta_wdata), .meta_rdata(meta_rdata), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .irq(irq));

	always #5 clk = ~clk;

	task automatic chk(logic [79:0] seen, logic [79:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize

	// idle response lines toggle so stale data never looks valid
	always @(posedge clk) begin
		meta_rdata <= !meta_rd ? eac_meta_type'(~meta_rdata) : meta_page == SI[31:12] ? m_si
			: meta_page == SRC[31:12] ? m_src : m_dst;
		mem_rdata <= !mem_rd ? ~mem_rdata : mem_addr == SI[31:3] ? w0
			: mem_addr[28:3] == SI[31:6] ? 64'h0 : {35'h0, mem_addr};
		if (mem_wr === 1'b1) begin
			n_wr++;
			chk(mem_wdata, {35'h0, mem_addr - DST[31:3] + SRC[31:3]});
		end
		if (meta_wr === 1'b1) begin
			n_mw++;
			chk(meta_wdata, em);
		end
	end

	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) bus <= '0;
	endtask : wr

	task automatic rd(logic [7:0] a, logic [31:0] e);
		@(posedge clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk) bus <= '0;
		#1 chk(bus_rdata, e);
	endtask : rd

	task automatic run(eac_op_type x);
		@(posedge clk) op <= x;
		op_valid <= 1;
		@(posedge clk) op_valid <= 0;
		for (n = 0; n < 3000; n++) begin
			#1;
			if ((gp_fault | pf_fault | done) === 1'b1)
				break;
			@(posedge clk);
		end
		if (n == 3000) begin
			n_mismatch++;
			$display("mismatch t=%0t no outcome", $time);
			summarize();
		end
	endtask : run

	function automatic eac_row_type mk(logic [31:0] s, d, c, logic [3:0] m, logic [2:0] t, g,
			logic [31:0] fa, logic [9:0] nw);
		mk = '{'{EAC_LEAF_ACCEPT_COPY, s, d, c, !m[0], m[3], m[2] ? 32'h0FFF_FFFF : 32'hFFFF_FFFF,
			{1'b0, m[3], 1'b0}, m[1]}, t, g, fa, nw};
	endfunction : mk

	initial begin
		rows = '{mk(SI, DST, SRC, 1, 0, 4, 0, 0),
			mk(SI, DST, SRC, 2, 0, 4, 0, 0),
			mk(SI, DST, SRC, 4, 0, 4, 0, 0),
			mk(SI, DST, SRC, 8, 0, 4, 0, 0),
			mk(SI + 8, DST, SRC, 0, 0, 4, 0, 0),
			mk(SI, DST, SRC + 16, 0, 0, 4, 0, 0),
			mk(SI, DST, 32'h2000_3000, 0, 0, 4, 0, 0),
			mk(FAR + 64, DST, FAR + 12288, 0, 0, 2, FAR + 64, 0),
			mk(SI, FAR + 8192, FAR + 12288, 0, 0, 2, FAR + 8192, 0),
			mk(SI, DST, FAR + 12288, 0, 0, 2, FAR + 12288, 0),
			mk(SI, DST, SRC, 0, 1, 2, SI, 0),
			mk(SI, DST, SRC, 0, 2, 4, 0, 0),
			mk(SI, DST, SRC, 0, 3, 2, SRC, 0),
			mk(SI, DST, SRC, 0, 5, 1, 0, 0),
			mk(SI, DST, SRC, 0, 6, 4, 0, 0),
			mk(SI, DST, SRC, 0, 4, 2, DST, 0),
			mk(SI, DST, SRC, 0, 0, 1, 0, 512)};
		repeat (20) @(posedge clk);
		reset <= 0;
		#1 chk({busy, done, gp_fault, pf_fault, irq, dest_claim, result_code, flags}, 0);
		rd(EAC_OFS_STATUS, 32'h0);
		wr(EAC_OFS_ELR_LO, 32'h1000_0000);
		wr(EAC_OFS_ELR_HI, 32'h1FFF_FFFF);
		wr(EAC_OFS_PPC_LO, 32'h1000_0000);
		wr(EAC_OFS_PPC_HI, 32'h10FF_FFFF);
		wr(EAC_OFS_ACTIVE, AID);
		wr(EAC_OFS_MASK, 32'h0000_000F);
		wr(EAC_OFS_RESULT, 32'hFFFF_FFFF);
		rd(EAC_OFS_RESULT, 32'h0);
		rd(EAC_OFS_ELR_HI, 32'h1FFF_FFFF);
		rd(8'h30, 32'h0);
		$display("register test done");
		foreach (rows[i]) begin
			r = rows[i];
			m_si = '{1, 1, 0, 0, 0, 0, 0, EAC_REGULAR_PAGE_TYPE, AID, SI};
			m_src = '{1, 1, 0, 0, 0, 0, 0, EAC_REGULAR_PAGE_TYPE, AID, SRC};
			m_dst = '{1, 1, 1, 0, 1, 0, 0, EAC_REGULAR_PAGE_TYPE, AID, DST};
			w0 = 64'h0000_0000_0000_0105;
			dest_in_use <= 0;
			case (r.t)
				1: m_si.blocked = 1;
				2: w0 = 64'h0000_0000_0000_0102;
				3: m_src.modified = 1;
				4: m_dst.x = 1;
				5: m_dst.pending = 0;
				6: dest_in_use <= 1;
				default: ;
			endcase
			em = m_dst;
			em.x = 1;
			em.pending = 0;
			n_wr = 0;
			n_mw = 0;
			run(r.op);
			chk({gp_fault, pf_fault, done}, r.gpd);
			if (!r.gpd[0])
				chk(fault_addr, r.fa);
			else begin
				chk(result_code, r.t == 3'h5 ? MIS : EAC_RESULT_OK);
				chk(flags, {r.t == 3'h5, 5'h00});
			end
			// the metadata write beside done is only counted at the next edge
			@(posedge clk) #1;
			for (n = 0; n < 8 && busy !== 1'b0; n++) @(posedge clk) #1;
			chk({busy, dest_claim, n_wr[9:0], n_mw[0]}, {12'h0, r.nw, r.nw != 0});
			$display("row %0d done", i);
		end
		o = rows[16].op;
		o.leaf = 32'h0000_0002;
		@(posedge clk) op <= o;
		op_valid <= 1;
		@(posedge clk) op_valid <= 0;
		#1 chk({busy, gp_fault, pf_fault}, 3'h0);
		$display("leaf test done");
		chk(irq, 1);
		rd(EAC_OFS_STATUS, 32'h0000_000F);
		wr(EAC_OFS_STATUS, 32'h0000_0005);
		rd(EAC_OFS_STATUS, 32'h0000_000A);
		wr(EAC_OFS_MASK, 32'h0000_0005);
		@(posedge clk) #1 chk(irq, 0);
		wr(EAC_OFS_STATUS, 32'h0000_000A);
		rd(EAC_OFS_STATUS, 32'h0);
		wr(EAC_OFS_MASK, 32'h0000_0002);
		run(rows[0].op);
		repeat (2) @(posedge clk);
		#1 chk(irq, 1);
		@(posedge clk) reset <= 1;
		@(posedge clk) reset <= 0;
		#1 chk({irq, busy, result_code}, 0);
		rd(EAC_OFS_MASK, 32'h0);
		$display("interrupt test done");
		// a write while the enable is low must not land
		ce <= 0;
		wr(EAC_OFS_MASK, 32'h0000_000F);
		ce <= 1;
		rd(EAC_OFS_MASK, 32'h0);
		$display("enable test done");
		summarize();
	end
endmodule : tb

bind eac_accept_copy eac_props #(.ATTR_MISMATCH_CODE(ATTR_MISMATCH_CODE)) i_props (
	.clk(clk), .reset(reset), .op_valid(op_valid), .op(op), .busy(busy), .done(done),
	.gp_fault(gp_fault), .pf_fault(pf_fault), .result_code(result_code), .flags(flags),
	.dest_claim(dest_claim), .meta_wr(meta_wr), .meta_wdata(meta_wdata), .mem_wr(mem_wr));
